/* File: src/lst_oc_add.sv */
`timescale 1ns/1ps
`default_nettype none

module lst_oc_add
    import lst_pkg::*;
#(
    parameter int W = 15
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    output logic      [W-1:0] sum
);
    logic [W:0] raw;

    // end-around carry keeps the sum in one's-complement form
    always_comb begin
        raw = {1'b0, a} + {1'b0, b};
        sum = raw[W-1:0] + {{(W-1){1'b0}}, raw[W]};
    end

endmodule : lst_oc_add

`default_nettype wire

/* File: src/lst_pkg.sv */
package lst_pkg;

    localparam int WORD_W = 24;
    localparam int ADDR_W = 15;
    localparam int CHAD_W = 17;
    localparam int CHAR_W = 6;
    localparam int FILE_N = 64;
    localparam int FSEL_W = 6;

    // instruction field positions
    localparam int OPC_MSB  = 23;
    localparam int OPC_LSB  = 18;
    localparam int IND_BIT  = 17;
    localparam int CXD_BIT  = 17;
    localparam int XD_MSB   = 16;
    localparam int XD_LSB   = 15;
    localparam int ADR_MSB  = 14;
    localparam int CHA_MSB  = 16;
    localparam int SUB_MSB  = 14;
    localparam int SUB_LSB  = 12;
    localparam int FSEL_MSB = 5;

    // opcodes (octal 21, 23, 26, 40..47, 53, 54, 55)
    localparam logic [5:0] OP_LOAD_AUX_WORD      = 6'h11;
    localparam logic [5:0] OP_LOAD_AUX_CHARACTER = 6'h13;
    localparam logic [5:0] OP_LOAD_PAIR_COMPL    = 6'h16;
    localparam logic [5:0] OP_STORE_ACCUM_WORD   = 6'h20;
    localparam logic [5:0] OP_STORE_AUX_WORD     = 6'h21;
    localparam logic [5:0] OP_STORE_ACCUM_CHAR   = 6'h22;
    localparam logic [5:0] OP_STORE_AUX_CHAR     = 6'h23;
    localparam logic [5:0] OP_STORE_WORD_ADDR    = 6'h24;
    localparam logic [5:0] OP_STORE_REG_PAIR     = 6'h25;
    localparam logic [5:0] OP_STORE_CHAR_ADDR    = 6'h26;
    localparam logic [5:0] OP_STORE_INDEX        = 6'h27;
    localparam logic [5:0] OP_XFER24             = 6'h2b;
    localparam logic [5:0] OP_LOAD_INDEX         = 6'h2c;
    localparam logic [5:0] OP_XFER48             = 6'h2d;

    // 24-bit transfer sub-codes: {instr[17], instr[14:12]}
    localparam logic [3:0] X_SUM_PAIR_TO_ACCUM   = 4'h0;
    localparam logic [3:0] X_SUM_INDEX_TO_ACCUM  = 4'h1;
    localparam logic [3:0] X_SUM_ACCUM_TO_INDEX  = 4'h2;
    localparam logic [3:0] X_MOVE_INDEX_TO_ACCUM = 4'h3;
    localparam logic [3:0] X_MOVE_ACCUM_TO_INDEX = 4'h4;
    localparam logic [3:0] X_MOVE_FILE_TO_AUX    = 4'h8;
    localparam logic [3:0] X_MOVE_AUX_TO_FILE    = 4'h9;
    localparam logic [3:0] X_MOVE_FILE_TO_ACCUM  = 4'ha;
    localparam logic [3:0] X_MOVE_ACCUM_TO_FILE  = 4'hb;
    localparam logic [3:0] X_MOVE_FILE_TO_INDEX  = 4'hc;
    localparam logic [3:0] X_MOVE_INDEX_TO_FILE  = 4'hd;

    // 48-bit transfer sub-codes: instr[14:12]; 0 and 4 are no-ops
    localparam logic [2:0] E_MOVE_LOW_EXT_TO_AUX    = 3'h1;
    localparam logic [2:0] E_MOVE_AUX_TO_LOW_EXT    = 3'h2;
    localparam logic [2:0] E_MOVE_HIGH_EXT_TO_ACCUM = 3'h3;
    localparam logic [2:0] E_MOVE_ACCUM_TO_HIGH_EXT = 3'h5;
    localparam logic [2:0] E_MOVE_EXT_TO_PAIR       = 3'h6;
    localparam logic [2:0] E_MOVE_PAIR_TO_EXT       = 3'h7;

    localparam logic [ADDR_W-1:0] ADDR_ONE  = 15'h0001;
    localparam logic [WORD_W-1:0] WORD_ZERO = 24'h000000;

    typedef enum logic [2:0] {
        ST_IDLE, ST_IND, ST_IX, ST_CHR, ST_RD1, ST_RD2, ST_MOD, ST_WR
    } lst_state_e;

    typedef struct packed {
        logic              start;
        logic [WORD_W-1:0] instr;
    } lst_cmd_s;

    typedef struct packed {
        logic              req;
        logic              we;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } lst_mem_s;

    typedef struct packed {
        logic busy;
        logic done;
        logic trap;
    } lst_stat_s;

endpackage : lst_pkg

/* File: src/lst_reg_file.sv */
`timescale 1ns/1ps
`default_nettype none

module lst_reg_file
    import lst_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire logic              we,
    input  wire logic [FSEL_W-1:0] waddr,
    input  wire logic [WORD_W-1:0] wdata,
    input  wire logic [FSEL_W-1:0] raddr,
    output logic      [WORD_W-1:0] rdata
);
    typedef struct packed {
        logic [FILE_N-1:0][WORD_W-1:0] ent;
    } lst_file_s;

    lst_file_s s_q;
    lst_file_s s_d;

    always_comb begin
        s_d = s_q;
        if (we) begin
            s_d.ent[waddr] = wdata;
        end
        rdata = s_q.ent[raddr];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

endmodule : lst_reg_file

`default_nettype wire

/* File: src/lst_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module lst_unit
    import lst_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst,
    input  wire lst_cmd_s          cmd,
    input  wire logic              float_double_option,
    input  wire logic              mem_ack,
    input  wire logic [WORD_W-1:0] mem_rdata,
    output lst_mem_s               mem,
    output lst_stat_s              stat,
    output logic      [WORD_W-1:0] accum,
    output logic      [WORD_W-1:0] aux
);
    typedef struct packed {
        lst_state_e               st;
        logic [5:0]               op;
        logic [1:0]               xd;
        logic [ADDR_W-1:0]        base;
        logic [ADDR_W-1:0]        addr;
        logic [1:0]               cpos;
        logic [WORD_W-1:0]        acc;
        logic [WORD_W-1:0]        aux;
        logic [2:0][ADDR_W-1:0]   xr;
        logic [2*WORD_W-1:0]      ext;
        lst_mem_s                 mem;
        lst_stat_s                stat;
    } lst_unit_s;

    lst_unit_s s_q;
    lst_unit_s s_d;

    function automatic logic [ADDR_W-1:0] idx_of(input logic [2:0][ADDR_W-1:0] xr,
                                                 input logic [1:0] d);
        if (d == 2'd0) begin
            idx_of = '0;
        end else begin
            idx_of = xr[d - 2'd1];
        end
    endfunction : idx_of

    function automatic logic [CHAR_W-1:0] get_char(input logic [WORD_W-1:0] w,
                                                   input logic [1:0] p);
        // character 0 is the leftmost six bits of the word
        get_char = w[(3 - p) * CHAR_W +: CHAR_W];
    endfunction : get_char

    function automatic logic [WORD_W-1:0] put_char(input logic [WORD_W-1:0] w,
                                                   input logic [1:0] p,
                                                   input logic [CHAR_W-1:0] c);
        put_char = w;
        put_char[(3 - p) * CHAR_W +: CHAR_W] = c;
    endfunction : put_char

    logic [5:0]        in_op;
    logic [1:0]        in_xd;
    logic [3:0]        in_sub;
    logic [ADDR_W-1:0] in_idx;
    logic [WORD_W-1:0] add24_b;
    logic [WORD_W-1:0] sum24;
    logic [ADDR_W-1:0] add15_a;
    logic [ADDR_W-1:0] add15_b;
    logic [ADDR_W-1:0] sum15;
    logic [CHAD_W-1:0] chx;
    logic [CHAD_W-1:0] sum17;
    logic [ADDR_W-1:0] q_idx;
    logic              f_we;
    logic [WORD_W-1:0] f_wdata;
    logic [WORD_W-1:0] f_rdata;

    assign in_op  = cmd.instr[OPC_MSB:OPC_LSB];
    assign in_xd  = cmd.instr[XD_MSB:XD_LSB];
    assign in_sub = {cmd.instr[IND_BIT], cmd.instr[SUB_MSB:SUB_LSB]};
    assign in_idx = idx_of(s_q.xr, in_xd);
    assign q_idx  = idx_of(s_q.xr, s_q.xd);

    // index value widened with its sign before the accumulator sum
    assign add24_b = (in_sub == X_SUM_PAIR_TO_ACCUM) ? s_q.aux
                   : {{(WORD_W-ADDR_W){in_idx[ADDR_W-1]}}, in_idx};
    lst_oc_add #(.W(WORD_W)) u_add24 (
        .a   (s_q.acc),
        .b   (add24_b),
        .sum (sum24)
    );

    // second word of a pair is addr+1 in one's complement, so 77777 wraps to 00001
    assign add15_a = (s_q.st == ST_IX) ? s_q.base : s_q.addr;
    assign add15_b = (s_q.st == ST_IX) ? q_idx : ADDR_ONE;
    lst_oc_add #(.W(ADDR_W)) u_add15 (
        .a   (add15_a),
        .b   (add15_b),
        .sum (sum15)
    );

    // store-accum-char uses index 2, the aux char ops use index 1
    assign chx = (s_q.op == OP_STORE_ACCUM_CHAR)
               ? {{2{s_q.xr[1][ADDR_W-1]}}, s_q.xr[1]}
               : {{2{s_q.xr[0][ADDR_W-1]}}, s_q.xr[0]};
    lst_oc_add #(.W(CHAD_W)) u_add17 (
        .a   ({s_q.xd[1], s_q.base, s_q.xd[0]}),
        .b   (s_q.cpos[0] ? chx : {CHAD_W{1'b0}}),
        .sum (sum17)
    );

    lst_reg_file u_file (
        .mclk  (mclk),
        .rst   (rst),
        .we    (f_we),
        .waddr (cmd.instr[FSEL_MSB:0]),
        .wdata (f_wdata),
        .raddr (cmd.instr[FSEL_MSB:0]),
        .rdata (f_rdata)
    );

    always_comb begin
        s_d           = s_q;
        s_d.stat.done = 1'b0;
        s_d.stat.trap = 1'b0;
        f_we          = 1'b0;
        f_wdata       = WORD_ZERO;
        case (s_q.st)
            ST_IDLE: begin
                if (cmd.start) begin
                    s_d.op        = in_op;
                    s_d.xd        = in_xd;
                    s_d.base      = cmd.instr[ADR_MSB:0];
                    s_d.stat.busy = 1'b1;
                    case (in_op)
                        OP_XFER24: begin
                            s_d.stat.done = 1'b1;
                            s_d.stat.busy = 1'b0;
                            case (in_sub)
                                X_SUM_PAIR_TO_ACCUM:   s_d.acc = sum24;
                                X_SUM_INDEX_TO_ACCUM:  s_d.acc = sum24;
                                X_SUM_ACCUM_TO_INDEX: begin
                                    if (in_xd != 2'd0) begin
                                        s_d.xr[in_xd - 2'd1] = sum24[ADDR_W-1:0];
                                    end
                                end
                                X_MOVE_INDEX_TO_ACCUM: s_d.acc = {9'h000, in_idx};
                                X_MOVE_ACCUM_TO_INDEX: begin
                                    if (in_xd != 2'd0) begin
                                        s_d.xr[in_xd - 2'd1] = s_q.acc[ADDR_W-1:0];
                                    end
                                end
                                X_MOVE_FILE_TO_AUX:    s_d.aux = f_rdata;
                                X_MOVE_FILE_TO_ACCUM:  s_d.acc = f_rdata;
                                X_MOVE_AUX_TO_FILE: begin
                                    f_we    = 1'b1;
                                    f_wdata = s_q.aux;
                                end
                                X_MOVE_ACCUM_TO_FILE: begin
                                    f_we    = 1'b1;
                                    f_wdata = s_q.acc;
                                end
                                X_MOVE_FILE_TO_INDEX: begin
                                    if (in_xd != 2'd0) begin
                                        s_d.xr[in_xd - 2'd1] = f_rdata[ADDR_W-1:0];
                                    end
                                end
                                X_MOVE_INDEX_TO_FILE: begin
                                    f_we    = 1'b1;
                                    f_wdata = {9'h000, in_idx};
                                end
                                default: ;
                            endcase
                        end
                        OP_XFER48: begin
                            s_d.stat.busy = 1'b0;
                            if (!float_double_option) begin
                                s_d.stat.trap = 1'b1;
                            end else begin
                                s_d.stat.done = 1'b1;
                                case (in_sub[2:0])
                                    E_MOVE_LOW_EXT_TO_AUX:    s_d.aux = s_q.ext[WORD_W-1:0];
                                    E_MOVE_AUX_TO_LOW_EXT:    s_d.ext[WORD_W-1:0] = s_q.aux;
                                    E_MOVE_HIGH_EXT_TO_ACCUM: s_d.acc = s_q.ext[2*WORD_W-1:WORD_W];
                                    E_MOVE_ACCUM_TO_HIGH_EXT: s_d.ext[2*WORD_W-1:WORD_W] = s_q.acc;
                                    E_MOVE_EXT_TO_PAIR:       {s_d.acc, s_d.aux} = s_q.ext;
                                    E_MOVE_PAIR_TO_EXT:       s_d.ext = {s_q.acc, s_q.aux};
                                    default: ;
                                endcase
                            end
                        end
                        OP_LOAD_AUX_CHARACTER, OP_STORE_ACCUM_CHAR,
                        OP_STORE_AUX_CHAR: begin
                            // r is 17 bits: park the low bit in xd[0], the
                            // top bit in xd[1]; cpos[0] keeps the designator
                            s_d.xd   = {cmd.instr[CHA_MSB], cmd.instr[0]};
                            s_d.base = cmd.instr[ADR_MSB+1:1];
                            s_d.cpos = {1'b0, cmd.instr[CXD_BIT]};
                            s_d.st   = ST_CHR;
                        end
                        OP_LOAD_AUX_WORD, OP_LOAD_PAIR_COMPL, OP_LOAD_INDEX,
                        OP_STORE_ACCUM_WORD, OP_STORE_AUX_WORD, OP_STORE_WORD_ADDR,
                        OP_STORE_REG_PAIR, OP_STORE_CHAR_ADDR, OP_STORE_INDEX: begin
                            if (cmd.instr[IND_BIT]) begin
                                s_d.st       = ST_IND;
                                s_d.mem.req  = 1'b1;
                                s_d.mem.we   = 1'b0;
                                s_d.mem.addr = cmd.instr[ADR_MSB:0];
                            end else begin
                                s_d.st = ST_IX;
                            end
                        end
                        default: begin
                            s_d.stat.done = 1'b1;
                            s_d.stat.busy = 1'b0;
                        end
                    endcase
                end
            end
            ST_IND: begin
                if (mem_ack) begin
                    // only the mode bit and address of each link matter
                    s_d.base = mem_rdata[ADR_MSB:0];
                    s_d.mem.addr = mem_rdata[ADR_MSB:0];
                    if (!mem_rdata[IND_BIT]) begin
                        s_d.mem.req = 1'b0;
                        s_d.st      = ST_IX;
                    end
                end
            end
            ST_IX: begin
                if (s_q.op == OP_LOAD_INDEX || s_q.op == OP_STORE_INDEX) begin
                    s_d.addr = s_q.base;
                end else begin
                    s_d.addr = sum15;
                end
                s_d.mem.req  = 1'b1;
                s_d.mem.addr = s_d.addr;
                s_d.cpos     = '0;
                case (s_q.op)
                    OP_LOAD_AUX_WORD, OP_LOAD_PAIR_COMPL, OP_LOAD_INDEX: begin
                        s_d.mem.we = 1'b0;
                        s_d.st     = ST_RD1;
                    end
                    OP_STORE_ACCUM_WORD, OP_STORE_REG_PAIR: begin
                        s_d.mem.we    = 1'b1;
                        s_d.mem.wdata = s_q.acc;
                        s_d.st        = ST_WR;
                    end
                    OP_STORE_AUX_WORD: begin
                        s_d.mem.we    = 1'b1;
                        s_d.mem.wdata = s_q.aux;
                        s_d.st        = ST_WR;
                    end
                    default: begin
                        s_d.mem.we = 1'b0;
                        s_d.st     = ST_MOD;
                    end
                endcase
            end
            ST_CHR: begin
                s_d.addr     = sum17[CHAD_W-1:2];
                s_d.cpos     = sum17[1:0];
                s_d.mem.req  = 1'b1;
                s_d.mem.we   = 1'b0;
                s_d.mem.addr = sum17[CHAD_W-1:2];
                s_d.st       = (s_q.op == OP_LOAD_AUX_CHARACTER) ? ST_RD1 : ST_MOD;
            end
            ST_RD1: begin
                if (mem_ack) begin
                    s_d.mem.req   = 1'b0;
                    s_d.stat.done = 1'b1;
                    s_d.stat.busy = 1'b0;
                    s_d.st        = ST_IDLE;
                    case (s_q.op)
                        OP_LOAD_AUX_WORD: s_d.aux = mem_rdata;
                        OP_LOAD_AUX_CHARACTER:
                            s_d.aux = {18'h00000, get_char(mem_rdata, s_q.cpos)};
                        OP_LOAD_INDEX: begin
                            if (s_q.xd != 2'd0) begin
                                s_d.xr[s_q.xd - 2'd1] = mem_rdata[ADDR_W-1:0];
                            end
                        end
                        default: begin
                            s_d.acc       = ~mem_rdata;
                            s_d.addr      = sum15;
                            s_d.mem.req   = 1'b1;
                            s_d.mem.addr  = sum15;
                            s_d.stat.done = 1'b0;
                            s_d.stat.busy = 1'b1;
                            s_d.st        = ST_RD2;
                        end
                    endcase
                end
            end
            ST_RD2: begin
                if (mem_ack) begin
                    s_d.aux       = ~mem_rdata;
                    s_d.mem.req   = 1'b0;
                    s_d.stat.done = 1'b1;
                    s_d.stat.busy = 1'b0;
                    s_d.st        = ST_IDLE;
                end
            end
            ST_MOD: begin
                if (mem_ack) begin
                    s_d.mem.we = 1'b1;
                    s_d.st     = ST_WR;
                    case (s_q.op)
                        OP_STORE_ACCUM_CHAR:
                            s_d.mem.wdata = put_char(mem_rdata, s_q.cpos, s_q.acc[CHAR_W-1:0]);
                        OP_STORE_AUX_CHAR:
                            s_d.mem.wdata = put_char(mem_rdata, s_q.cpos, s_q.aux[CHAR_W-1:0]);
                        OP_STORE_CHAR_ADDR:
                            s_d.mem.wdata = {mem_rdata[WORD_W-1:CHAD_W], s_q.acc[CHAD_W-1:0]};
                        OP_STORE_INDEX:
                            s_d.mem.wdata = {mem_rdata[WORD_W-1:ADDR_W], q_idx};
                        default:
                            s_d.mem.wdata = {mem_rdata[WORD_W-1:ADDR_W], s_q.acc[ADDR_W-1:0]};
                    endcase
                end
            end
            ST_WR: begin
                if (mem_ack) begin
                    // a flag, not a data compare: equal accum and aux must not loop
                    if (s_q.op == OP_STORE_REG_PAIR && !s_q.cpos[0]) begin
                        s_d.cpos[0]   = 1'b1;
                        s_d.addr      = sum15;
                        s_d.mem.addr  = sum15;
                        s_d.mem.wdata = s_q.aux;
                    end else begin
                        s_d.mem.req   = 1'b0;
                        s_d.mem.we    = 1'b0;
                        s_d.stat.done = 1'b1;
                        s_d.stat.busy = 1'b0;
                        s_d.st        = ST_IDLE;
                    end
                end
            end
            default: s_d.st = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            s_q    <= '0;
            s_q.st <= ST_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign mem   = s_q.mem;
    assign stat  = s_q.stat;
    assign accum = s_q.acc;
    assign aux   = s_q.aux;

endmodule : lst_unit

`default_nettype wire

/* File: tb/lst_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lst_mem_model
    import lst_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire logic [1:0]        lag,
    input wire lst_mem_s          mem,
    output logic                  mem_ack,
    output logic [WORD_W-1:0]     mem_rdata
);
    logic [WORD_W-1:0] cells [0:32767];
    logic [1:0]        cnt;
    // outside the ack cycle data toggles so stale reads show
    // plain always: the bench preloads cells from outside
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            mem_ack <= 1'b0;
            cnt     <= 2'h0;
        end else if (mem.req && !mem_ack && cnt >= lag) begin
            mem_ack   <= 1'b1;
            cnt       <= 2'h0;
            mem_rdata <= cells[mem.addr];
            if (mem.we) cells[mem.addr] <= mem.wdata;
        end else begin
            mem_ack   <= 1'b0;
            mem_rdata <= ~mem_rdata;
            if (mem.req && !mem_ack) cnt <= cnt + 2'h1;
        end
    end
endmodule : lst_mem_model
`default_nettype wire

/* File: tb/lst_unit_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module lst_unit_checker
    import lst_pkg::*;
(
    input wire logic              mclk,
    input wire logic              rst,
    input wire lst_cmd_s          cmd,
    input wire logic              float_double_option,
    input wire logic              mem_ack,
    input wire lst_mem_s          mem,
    input wire lst_stat_s         stat,
    input wire logic [WORD_W-1:0] accum,
    input wire logic [WORD_W-1:0] aux
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (rst);
    // start in a done cycle is not counted, the bench never does it
    wire logic       go = cmd.start && !stat.busy && !stat.done && !stat.trap;
    wire logic [5:0] op = cmd.instr[OPC_MSB:OPC_LSB];
    a_trap_no_opt: assert property (
        go && op == OP_XFER48 && !float_double_option |=> stat.trap)
        else $error("missing trap");
    a_opt_no_trap: assert property (
        go && op == OP_XFER48 && float_double_option |=> !stat.trap)
        else $error("trap with option");
    a_trap_keeps: assert property (
        stat.trap |-> $stable(accum) && $stable(aux))
        else $error("trap changed registers");
    a_xfer_quick: assert property (
        go && op == OP_XFER24 |=> stat.done && !mem.req)
        else $error("transfer not done in one cycle");
    a_req_held: assert property (
        mem.req && !mem_ack |=> mem.req && $stable(mem.addr) && $stable(mem.we))
        else $error("storage request dropped");
    a_store_src: assert property (
        mem.req && mem.we |-> $stable(accum) && $stable(aux))
        else $error("store changed source");
    // a start in the done cycle may legally give a second pulse
    a_done_pulse: assert property (
        (stat.done || stat.trap) && !cmd.start |=> !stat.done && !stat.trap)
        else $error("status pulse too long");
    a_idle_noreq: assert property (
        !stat.busy |-> !mem.req)
        else $error("request while idle");
endmodule : lst_unit_checker
`default_nettype wire

/* File: tb/lst_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module lst_unit_tb
    import lst_pkg::*;
;
    logic mclk = 0, rst, float_double_option, mem_ack;
    logic [1:0] lag;
    logic [WORD_W-1:0] mem_rdata, accum, aux;
    lst_cmd_s cmd;
    lst_mem_s mem;
    lst_stat_s stat;
    int num_errors = 0, checked = 0, cyc = 0;
    lst_unit u_lst_unit (.mclk(mclk), .rst(rst), .cmd(cmd),
        .float_double_option(float_double_option), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .mem(mem), .stat(stat), .accum(accum), .aux(aux));
    lst_mem_model u_lst_mem_model (.mclk(mclk), .rst(rst), .lag(lag), .mem(mem),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    initial forever #12.5 mclk = ~mclk;
    always @(posedge mclk) begin
        if (++cyc > 4000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : end_sim
    task automatic run(input logic [WORD_W-1:0] i);
        int n;
        @(posedge mclk);
        #2 cmd = {1'b1, i};
        @(posedge mclk);
        #2 cmd.start = 1'b0;
        for (n = 0; n < 40 && stat.done !== 1'b1 && stat.trap !== 1'b1; n++) begin
            @(posedge mclk);
            #2;
        end
        if (n == 40) begin
            num_errors++;
            end_sim();
        end
    endtask : run
    task automatic t_loads();
        run(24'h587fff); // pair load at 77777, second word from 00001
        `CHK("accum", 24'hf0f0f0, accum)
        `CHK("aux", 24'hfffedc, aux)
        run(24'h440010);
        `CHK("aux", 24'h100000, aux)
        run(24'hac0000); // f0f0f0 plus 100000 carries out and wraps round
        `CHK("accum", 24'h00f0f1, accum)
        `CHK("aux", 24'h100000, aux)
        $display("test loads done");
    endtask : t_loads
    task automatic t_stores();
        lag = 2'h2;
        run(24'h800020);
        `CHK("word", 24'h00f0f1, u_lst_mem_model.cells[15'h20])
        run(24'h940030);
        `CHK("pair lo", 24'h00f0f1, u_lst_mem_model.cells[15'h30])
        `CHK("pair hi", 24'h100000, u_lst_mem_model.cells[15'h31])
        run(24'h9c0040);
        `CHK("index", 24'hab8000, u_lst_mem_model.cells[15'h40])
        run(24'h980050);
        `CHK("chad", 24'hfef0f1, u_lst_mem_model.cells[15'h50])
        `CHK("accum", 24'h00f0f1, accum)
        lag = 2'h0;
        $display("test stores done");
    endtask : t_stores
    task automatic t_regs();
        run(24'h4c0017); // character 3 of word 5
        `CHK("char", 24'h000016, aux)
        run(24'hae3007);
        run(24'hae0007);
        `CHK("file", 24'h00f0f1, aux)
        `CHK("accum", 24'h00f0f1, accum)
        run(24'hb47000);
        `CHK("trap", 1'b1, stat.trap)
        float_double_option = 1'b1;
        run(24'hb47000);
        `CHK("no trap", 1'b0, stat.trap)
        $display("test regs done");
    endtask : t_regs
    task automatic t_index();
        run(24'hb28060); // index 1 through link at 60; the link's designator is ignored
        run(24'hacb000);
        `CHK("index", 24'h007ffe, accum)
        run(24'hac9000);
        `CHK("sum", 24'h007ffd, accum)
        run(24'h8e0015); // char 1 of word 5, moved back one by index 1
        `CHK("char", 24'hc63456, u_lst_mem_model.cells[15'h05])
        run(24'h908042); // 42 plus index 1 gives word 41
        `CHK("word addr", 24'hfffffd, u_lst_mem_model.cells[15'h41])
        $display("test index done");
    endtask : t_index
    initial begin
        rst = 1'b1;
        cmd = '0;
        float_double_option = 1'b0;
        lag = 2'h0;
        u_lst_mem_model.cells[15'h7fff] = 24'h0f0f0f;
        u_lst_mem_model.cells[15'h0001] = 24'h000123;
        u_lst_mem_model.cells[15'h0010] = 24'h100000;
        u_lst_mem_model.cells[15'h0040] = 24'habcdef;
        u_lst_mem_model.cells[15'h0050] = 24'hffffff;
        u_lst_mem_model.cells[15'h0005] = 24'h123456;
        u_lst_mem_model.cells[15'h0060] = 24'hf98070;
        u_lst_mem_model.cells[15'h0070] = 24'h2b7ffe;
        u_lst_mem_model.cells[15'h0041] = 24'hffffff;
        repeat (8) @(posedge mclk);
        #2 rst = 1'b0;
        t_loads();
        t_stores();
        t_regs();
        t_index();
        end_sim();
    end
endmodule : lst_unit_tb
bind lst_unit lst_unit_checker u_lst_unit_checker (.mclk(mclk), .rst(rst), .cmd(cmd),
    .float_double_option(float_double_option), .mem_ack(mem_ack), .mem(mem), .stat(stat),
    .accum(accum), .aux(aux));
`default_nettype wire
